/* sahc_pkg.sv */
// Package of constants and types for the converter host-control block.
package sahc_pkg;

  // ****************************************************************
  // Timing in converter clock periods, clock divider and result bit layout
  // ****************************************************************
  localparam int unsigned ACQ_PERIODS_MIN = 6;
  localparam int unsigned AZ_PERIODS = 26;
  localparam int unsigned CONV_PERIODS = 27;
  localparam int unsigned CAL_PERIODS = 1399;
  localparam int unsigned DIV_DEFAULT = 36;
  localparam int unsigned RES_W = 13;
  localparam int unsigned SIGN_BIT = 12;
  localparam int unsigned HI_LO = 8;
  localparam int unsigned HI_HI = 11;

  typedef enum {
    ST_IDLE,
    ST_CAL,
    ST_AZ,
    ST_ACQ_WR,
    ST_ACQ_SH,
    ST_CONV
  } sahc_state_e;

  // Host strobes, all active low, already synchronised.
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic sh_n;
    logic cal_n;
    logic auto_zero_n;
  } sahc_host_s;

  // Correction values: ladder from the last calibration, offset from the last calibration or auto-zero phase.
  typedef struct packed {
    logic [7:0] offset;
    logic [7:0] ladder;
  } sahc_corr_s;

endpackage

/* sahc_sync.sv */
// Two-stage synchroniser for a group of asynchronous host inputs.
module sahc_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sahc_sync

/* sahc_sar.sv */
// Successive-approximation engine that resolves sign and 12 magnitude bits.
module sahc_sar
  import sahc_pkg::*;
#(
  parameter int W = RES_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  input wire logic step,
  input wire logic cmp,
  input wire sahc_corr_s corr,
  output logic done,
  output logic [W-1:0] result
);
  logic [W-1:0] trial;
  logic [W-1:0] mask;
  logic busy;

  // The comparator decision is inverted when bit 0 of the stored offset is set.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      trial <= '0;
      mask <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      result <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        trial <= '0;
        mask <= {1'b1, {(W-1){1'b0}}};
        busy <= 1'b1;
      end else if (busy && step) begin
        if (cmp ^ corr.offset[0]) begin
          trial <= trial | mask;
        end
        mask <= mask >> 1;
        if (mask[0]) begin
          busy <= 1'b0;
          done <= 1'b1;
          result <= (cmp ^ corr.offset[0]) ? (trial | mask) : trial;
        end
      end
    end
  end
endmodule // sahc_sar

/* sahc_ctrl.sv */
// Control and host interface of a self-calibrating 12-bit plus sign converter.
//
// Overview of operation
// - With chip select low, rising write strobe starts a conversion.
// - Write-started conversions end acquisition internally.
// - Asynchronous write: acquisition ends 6 to 6.5 clock periods after edge.
// - Clock falling edge aligned with write: acquisition ends at 6.5 periods.
// - Sample/hold control has no one-period acquisition uncertainty.
// - Falling sample/hold with chip select low opens acquisition.
// - Rising sample/hold closes acquisition and starts conversion at once.
// - Write, read and sample/hold count only while chip select is low.
// - Chip select and read low: drive data pins and raise interrupt.
// - Calibrate low resets the device and starts calibration.
// - Calibration measures offset and ladder and stores both; only the offset is applied.
// - Auto-zero low inserts an offset-correcting phase before write-started conversions.
// - Auto-zero lengthens conversion by 26 clock periods.
// - End-of-conversion low during auto-zero, conversion or calibration, else high.
// - Interrupt goes low when the result is latched.
// - Interrupt returns high on read, new conversion or calibration.
// - Host reads two bytes: high byte first, then low byte.
// - Result is two's complement, sign at bit 12, MSB at bit 11.
// - Calibration holds end-of-conversion low for 1399 clock periods.
// - First read: low nibble bits 8..11, high nibble sign repeated.
// - Second read: result bits 0..7, LSB on lowest line.
module sahc_ctrl
  import sahc_pkg::*;
#(
  parameter int unsigned CLK_DIV = DIV_DEFAULT,
  parameter int unsigned CAL_LEN = CAL_PERIODS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic conv_clk,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic sh_n,
  input wire logic cal_n,
  input wire logic auto_zero_n,
  input wire logic comparator,
  output logic eoc,
  output logic int_n,
  output logic [7:0] data_out_pins,
  output logic data_out_pins_oe,
  output logic sampling
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  sahc_host_s host;
  logic clk_s;
  logic cmp_s;
  logic [7:0] pins_s;

  // The converter clock is oversampled through the same synchroniser, so it
  // must stay well below half the system clock or its edges are lost.
  sahc_sync #(.W(8), .INIT(8'hFF)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .d({cs_n, wr_n, rd_n, sh_n, cal_n, auto_zero_n, conv_clk, comparator}),
    .q(pins_s)
  );

  assign host = pins_s[7:2];
  assign clk_s = pins_s[1];
  assign cmp_s = pins_s[0];

  // ****************************************************************
  // Edge detection on synchronised inputs
  // ****************************************************************
  sahc_host_s host_q;
  logic clk_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      host_q <= '1;
      // Matches the synchroniser's reset level, so no false edge follows reset.
      clk_q <= 1'b1;
    end else begin
      host_q <= host;
      clk_q <= clk_s;
    end
  end

  logic sel;
  logic clk_rise;
  logic clk_fall;
  logic wr_start;
  logic sh_open;
  logic sh_close;
  logic rd_active;
  logic rd_end;
  logic cal_req;
  logic restart;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  // The analog input is tracked in these states; end-of-conversion falls at
  // the hold instant and is also low in auto-zero, but stays high through them.
  function automatic logic in_acquisition(input sahc_state_e s);
    return (s == ST_ACQ_WR) || (s == ST_ACQ_SH);
  endfunction

  // Any start or calibration request restarts the device, which clears the
  // interrupt and points the byte selector back at the high byte.
  function automatic logic is_restart(input logic wr, input logic sh, input logic cal);
    return wr || sh || cal;
  endfunction

  assign sel = ~host.cs_n;
  assign clk_rise = clk_s & ~clk_q;
  assign clk_fall = ~clk_s & clk_q;
  assign wr_start = sel && host.wr_n && !host_q.wr_n;
  assign sh_open = sel && !host.sh_n && host_q.sh_n;
  // The closing edge counts only while selected, like the write and read strobes;
  // a host that drops chip select first leaves acquisition open.
  assign sh_close = sel && host.sh_n && !host_q.sh_n;
  assign rd_active = sel && !host.rd_n;
  assign rd_end = !(~host_q.cs_n && !host_q.rd_n) ? 1'b0 : !rd_active;
  assign cal_req = !host.cal_n;
  assign restart = is_restart(wr_start, sh_open, cal_req);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  sahc_state_e state;
  logic [11:0] cnt;
  logic sar_start;
  logic sar_done;
  logic [RES_W-1:0] sar_res;
  sahc_corr_s corr;
  logic finishing;

  // A conversion counts as finished only if the sequencer still waits for it;
  // an engine run cut short by a restart must not reach the output latch.
  assign finishing = sar_done && (state == ST_CONV);

  // Periods are counted on converter clock edges; a write start counts half
  // periods so that a coincident falling edge yields exactly 6.5 periods.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_CAL;
      cnt <= '0;
      sar_start <= 1'b0;
    end else begin
      sar_start <= 1'b0;
      if (cal_req && state != ST_CAL) begin
        state <= ST_CAL;
        cnt <= '0;
      end else begin
        unique case (state)
          ST_IDLE, ST_CONV: begin
            if (state == ST_CONV && sar_done) begin
              state <= ST_IDLE;
            end
            // A write during a conversion restarts it; the stored corrections
            // may then be spoiled, so the host should recalibrate afterwards.
            if (wr_start && !cal_req) begin
              cnt <= '0;
              state <= host.auto_zero_n ? ST_ACQ_WR : ST_AZ;
            end else if (sh_open) begin
              state <= ST_ACQ_SH;
            end
          end
          ST_CAL: begin
            // Calibration cannot be cut short once running.
            if (clk_rise && !cal_req) begin
              cnt <= cnt + 12'h001;
              if (cnt == 12'(CAL_LEN - 1)) begin
                state <= ST_IDLE;
                cnt <= '0;
              end
            end
          end
          ST_AZ: begin
            // A write inside the auto-zero phase starts it again; nothing has
            // been sampled yet, so the stored corrections are not at risk.
            if (wr_start) begin
              cnt <= '0;
            end else if (clk_rise) begin
              cnt <= cnt + 12'h001;
              if (cnt == 12'(AZ_PERIODS - 1)) begin
                state <= ST_ACQ_WR;
                cnt <= '0;
              end
            end
          end
          ST_ACQ_WR: begin
            // Later write edges are ignored here, because restarting in the
            // middle of a sample would corrupt the stored corrections.
            if (clk_rise || clk_fall) begin
              cnt <= cnt + 12'h001;
              if (cnt == 12'(2 * ACQ_PERIODS_MIN)) begin
                state <= ST_CONV;
                sar_start <= 1'b1;
              end
            end
          end
          ST_ACQ_SH: begin
            if (sh_close) begin
              state <= ST_CONV;
              sar_start <= 1'b1;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Calibration memory
  // ****************************************************************
  // Offset and ladder mismatch are sampled from the comparator during the
  // calibration run; the engine applies only offset bit 0 to later conversions.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      corr <= '0;
    end else if (state == ST_CAL && clk_rise) begin
      corr.offset <= {corr.offset[6:0], cmp_s};
      corr.ladder <= corr.ladder ^ {7'h00, cmp_s};
    end else if (state == ST_AZ && clk_rise) begin
      corr.offset <= {corr.offset[6:0], cmp_s};
    end
  end

  sahc_sar #(.W(RES_W)) u_sar (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(sar_start),
    .step(clk_rise),
    .cmp(cmp_s),
    .corr(corr),
    .done(sar_done),
    .result(sar_res)
  );

  // ****************************************************************
  // Output latch, interrupt and byte selector
  // ****************************************************************
  logic [RES_W-1:0] latch;
  logic low_next;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      latch <= '0;
    end else if (finishing) begin
      latch <= sar_res;
    end
  end

  // A completion in the same cycle as a read still drops the interrupt.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      int_n <= 1'b1;
    end else if (finishing) begin
      int_n <= 1'b0;
    end else if (rd_active || restart) begin
      int_n <= 1'b1;
    end
  end

  // The selector flips when a read ends, so a long read keeps presenting
  // one and the same byte.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      low_next <= 1'b0;
    end else if (restart) begin
      low_next <= 1'b0;
    end else if (rd_end) begin
      low_next <= ~low_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      data_out_pins <= '0;
      data_out_pins_oe <= 1'b0;
    end else begin
      data_out_pins_oe <= rd_active;
      if (low_next) begin
        data_out_pins <= latch[HI_LO-1:0];
      end else begin
        data_out_pins <= {{4{latch[SIGN_BIT]}}, latch[HI_HI:HI_LO]};
      end
    end
  end

  // End-of-conversion rises in the cycle in which the interrupt falls, unless calibrate is
  // low in that cycle, so a host that polls either flag already finds the result latched.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      eoc <= 1'b0;
      sampling <= 1'b0;
    end else begin
      eoc <= (state == ST_IDLE) || in_acquisition(state) || (finishing && !cal_req);
      sampling <= in_acquisition(state);
    end
  end

endmodule // sahc_ctrl

/* sahc_ctrl_assertions.sv */
// Port-level assertion checker for the converter host-control block.
module sahc_ctrl_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic sh_n,
  input wire logic cal_n,
  input wire logic eoc,
  input wire logic int_n,
  input wire logic data_out_pins_oe,
  input wire logic sampling
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  bus_released_a: assert property ((cs_n || rd_n) [*8] |-> !data_out_pins_oe)
    else $error("data pins driven outside a read");
  read_drives_a: assert property ((!cs_n && !rd_n) [*8] |-> data_out_pins_oe && int_n)
    else $error("read did not drive pins or clear int_n");
  write_no_cs_a: assert property ($rose(wr_n) && cs_n && cal_n && eoc && !sampling
    && sh_n |-> eoc [*8])
    else $error("write accepted without chip select");
  write_starts_a: assert property ($rose(wr_n) && !cs_n && eoc |-> ##[1:90] !eoc)
    else $error("write did not start a conversion");
  cal_busy_a: assert property ($fell(cal_n) |-> ##8 !eoc [*8])
    else $error("eoc high during calibration");
  cal_int_a: assert property ($fell(cal_n) |-> ##[1:8] int_n)
    else $error("calibration did not clear int_n");
  hold_open_a: assert property ($fell(sh_n) && !cs_n && eoc |-> ##[1:8] sampling)
    else $error("sample/hold did not open acquisition");
  hold_close_a: assert property ($rose(sh_n) && !cs_n && sampling |-> ##[1:8] !sampling && !eoc)
    else $error("sample/hold did not start conversion");
  done_flag_a: assert property ($fell(int_n) |-> ##[0:2] eoc)
    else $error("int_n fell while still converting");
endmodule // sahc_ctrl_checker

bind sahc_ctrl sahc_ctrl_checker chk (.clk_sys, .reset, .cs_n, .wr_n, .rd_n, .sh_n, .cal_n,
  .eoc, .int_n, .data_out_pins_oe, .sampling);

/* sahc_analog_model.sv */
// Behavioural converter clock source and comparator standing beside the block.
module sahc_analog_model #(
  parameter int HALF = 20
) (
  input wire logic level,
  output logic conv_clk,
  output logic comparator
);
  timeunit 1ns;
  timeprecision 1ps;
  // The converter clock runs free, in fixed phase with the system clock from time zero.
  initial conv_clk = 1'b0;
  always #(HALF) conv_clk = ~conv_clk;
  assign comparator = level;
endmodule // sahc_analog_model

/* tb_top.sv */
// Self-checking bench for the converter host-control block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sahc_pkg::*;
  logic clk_sys = 0;
  logic reset = 1;
  logic cs_n = 1, wr_n = 1, rd_n = 1, sh_n = 1, cal_n = 1, auto_zero_n = 1;
  logic conv_clk, comparator, eoc, int_n, data_out_pins_oe, sampling;
  logic [7:0] data_out_pins, hi, lo, b;
  int errors = 0, checked = 0, cyc = 0, t0, t1;

  always #2 clk_sys = ~clk_sys;

  // A short calibration keeps the run brief; timing checks assume ten system clocks per period.
  sahc_analog_model pm (.level(1'b1), .conv_clk, .comparator);
  sahc_ctrl #(.CAL_LEN(20)) DUT (.clk_sys, .reset, .conv_clk, .cs_n, .wr_n, .rd_n, .sh_n,
    .cal_n, .auto_zero_n, .comparator, .eoc, .int_n, .data_out_pins, .data_out_pins_oe,
    .sampling);

  task automatic check(input string what, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic till(input int s, input logic v);
    int n;
    n = 0;
    while ((s == 0 ? eoc : s == 1 ? int_n : sampling) !== v && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 3000) begin
      errors++;
    end
  endtask

  task automatic write(input logic c);
    @(posedge clk_sys);
    cs_n <= c;
    wr_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wr_n <= 1'b1;
    t0 = cyc;
    repeat (6) @(posedge clk_sys);
    cs_n <= 1'b1;
  endtask

  task automatic rd(output logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_sys);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    while (data_out_pins_oe !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    v = data_out_pins;
    check("oe", data_out_pins_oe, 1);
    check("int_n in read", int_n, 1);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    till(0, 1);
    @(posedge clk_sys);
    cal_n <= 1'b0;
    t0 = cyc;
    repeat (4) @(posedge clk_sys);
    cal_n <= 1'b1;
    till(0, 0);
    till(0, 1);
    check("cal time", (cyc - t0) inside {[195:225]}, 1);
    write(0);
    till(2, 1);
    till(2, 0);
    check("acq end", (cyc - t0) inside {[60:75]}, 1);
    till(1, 0);
    t1 = cyc - t0;
    check("eoc at done", eoc, 1);
    rd(hi);
    check("sign fill", hi[7:4], {4{hi[3]}});
    rd(lo);
    write(0);
    till(1, 0);
    rd(b);
    write(0);
    till(1, 0);
    write(1);
    repeat (30) @(posedge clk_sys);
    check("eoc no cs", eoc, 1);
    check("int no cs", int_n, 0);
    rd(b);
    check("first byte", b, hi);
    rd(b);
    check("second byte", b, lo);
    cs_n <= 1'b0;
    sh_n <= 1'b0;
    repeat (40) @(posedge clk_sys);
    check("sampling", sampling, 1);
    check("eoc open", eoc, 1);
    sh_n <= 1'b1;
    repeat (12) @(posedge clk_sys);
    check("hold", sampling, 0);
    check("eoc busy", eoc, 0);
    cs_n <= 1'b1;
    till(1, 0);
    auto_zero_n <= 1'b0;
    write(0);
    repeat (4) @(posedge clk_sys);
    check("int on start", int_n, 1);
    till(1, 0);
    check("az extra", (cyc - t0 - t1) inside {[245:275]}, 1);
    auto_zero_n <= 1'b1;
    summarize();
  end
endmodule // tb_top
